/* src/tbc_pkg.sv */
// Shared constants and types of the triggered bus capture block
package tbc_pkg;
	localparam int WORD_W      = 16;
	localparam int LANES       = 15;
	localparam int OWN_CLKS    = 10;
	localparam int TIMING_CLKS = 5;
	localparam int VOTE_MIN    = 3;
	localparam int READY_BIT   = 10;
	localparam int DEPTH_DEF   = 8192;
	localparam int DEPTH_MAX   = 65536;
	localparam int RX_DEPTH_DEF = 64;
	// Parameter word order on a load
	localparam logic [1:0] PARAM_SEL   = 2'h0;
	localparam logic [1:0] PARAM_TRIG  = 2'h1;
	localparam logic [1:0] PARAM_COUNT = 2'h2;
	// Host register byte offsets
	localparam logic [11:0] REG_CMD    = 12'h000;
	localparam logic [11:0] REG_SEL    = 12'h004;
	localparam logic [11:0] REG_TRIG   = 12'h008;
	localparam logic [11:0] REG_COUNT  = 12'h00c;
	localparam logic [11:0] REG_BYTES  = 12'h010;
	localparam logic [11:0] REG_CSR    = 12'h014;
	localparam logic [11:0] REG_ISTAT  = 12'h018;
	localparam logic [11:0] REG_IMASK  = 12'h01c;
	localparam logic [11:0] REG_RXBUF  = 12'h100;
	// Command register bits
	localparam int CMD_LOAD  = 0;
	localparam int CMD_START = 1;
	localparam int CMD_RESET = 2;
	localparam int CMD_READ  = 3;
	// Interrupt status bits
	localparam int IRQ_READY  = 0;
	localparam int IRQ_DONE   = 1;
	localparam int IRQ_REFUSE = 2;
	localparam int IRQ_W      = 3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [4:0] {
		TBC_IDLE   = 5'h01,
		TBC_SEARCH = 5'h02,
		TBC_STORE  = 5'h04,
		TBC_READY  = 5'h08,
		TBC_UNLOAD = 5'h10
	} tbc_dev_state_type;
	typedef enum logic [2:0] {
		TBC_H_IDLE = 3'h1,
		TBC_H_LOAD = 3'h2,
		TBC_H_DMA  = 3'h4
	} tbc_host_state_type;
endpackage

/* src/tbc_link_if.sv */
// Link between the capture device and the host end
`timescale 1ns/1ns
interface tbc_link_if;
	logic        start;
	logic        abort;
	logic        param_valid;
	logic [1:0]  param_sel;
	logic [15:0] param_data;
	logic        unload_req;
	logic        xfer_valid;
	logic        xfer_ready;
	logic        xfer_last;
	logic [15:0] xfer_data;
	logic [15:0] csr;
	modport device (
		input  start, abort, param_valid, param_sel, param_data, unload_req, xfer_ready,
		output xfer_valid, xfer_last, xfer_data, csr
	);
	modport host (
		output start, abort, param_valid, param_sel, param_data, unload_req, xfer_ready,
		input  xfer_valid, xfer_last, xfer_data, csr
	);
endinterface

/* src/tbc_sampler.sv */
// Lane synchroniser, clock vote and sampling edge selection
`timescale 1ns/1ns
module tbc_sampler
	import tbc_pkg::*;
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [LANES-1:0]       lane_data,
	input  wire logic [OWN_CLKS-1:0]    own_clk,
	input  wire logic [TIMING_CLKS-1:0] timing_clk,
	input  wire logic [3:0]             sel,
	output logic                        sample_edge,
	output logic [LANES-1:0]            sample_word
);
	typedef struct packed {
		logic [LANES-1:0]       d1;
		logic [LANES-1:0]       d2;
		logic [OWN_CLKS-1:0]    c1;
		logic [OWN_CLKS-1:0]    c2;
		logic [TIMING_CLKS-1:0] t1;
		logic [TIMING_CLKS-1:0] t2;
		logic                   prev;
		logic                   edge_hit;
		logic [LANES-1:0]       word;
	} tbc_smp_type;

	tbc_smp_type s;
	tbc_smp_type next_s;

	function automatic logic majority(input logic [TIMING_CLKS-1:0] v);
		int n;
		n = 0;
		for (int i = 0; i < TIMING_CLKS; i++) begin
			n = n + int'(v[i]);
		end
		return n >= VOTE_MIN;
	endfunction

	always_comb begin
		logic clk_now;
		clk_now = 1'b0;
		next_s = s;
		next_s.d1 = lane_data;
		next_s.d2 = s.d1;
		next_s.c1 = own_clk;
		next_s.c2 = s.c1;
		next_s.t1 = timing_clk;
		next_s.t2 = s.t1;
		if (sel < 4'(OWN_CLKS)) begin
			clk_now = s.c2[sel];
		end else if (sel < 4'(LANES)) begin
			clk_now = majority(s.t2);
		end
		next_s.prev = clk_now;
		next_s.edge_hit = clk_now & ~s.prev;
		if (clk_now & ~s.prev) begin
			next_s.word = s.d2;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sample_edge = s.edge_hit;
	assign sample_word = s.word;
endmodule

/* src/tbc_device.sv */
// Capture device end: trigger search, word storage and unload
`timescale 1ns/1ns
module tbc_device
	import tbc_pkg::*;
#(
	parameter int DEPTH = DEPTH_DEF
)(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [LANES-1:0]       lane_data,
	input  wire logic [OWN_CLKS-1:0]    own_clk,
	input  wire logic [TIMING_CLKS-1:0] timing_clk,
	tbc_link_if.device                  link
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	if (DEPTH < 1 || DEPTH > DEPTH_MAX) begin : g_bad_depth
		$error("tbc_device: DEPTH out of range");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		tbc_dev_state_type              state;
		logic [WORD_W-1:0]              sel_code;
		logic [WORD_W-1:0]              trig;
		logic [WORD_W-1:0]              count;
		logic [WORD_W-1:0]              shreg;
		logic [WORD_W-1:0]              addr;
		logic [WORD_W-1:0]              uaddr;
		logic [DEPTH-1:0][WORD_W-1:0]   mem;
		logic                           xv;
		logic                           xl;
		logic [WORD_W-1:0]              xd;
		logic                           triggered;
		logic                           clipped;
		logic [WORD_W-1:0]              csr;
	} tbc_dev_type;

	tbc_dev_type s;
	tbc_dev_type next_s;

	logic             sample_edge;
	logic [LANES-1:0] sample_word;

	// ****************************************************************
	// Lane sampling
	// ****************************************************************
	tbc_sampler u_sampler (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.lane_data   (lane_data),
		.own_clk     (own_clk),
		.timing_clk  (timing_clk),
		.sel         (s.sel_code[3:0]),
		.sample_edge (sample_edge),
		.sample_word (sample_word)
	);

	function automatic logic at_end(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] c);
		return (a == c) || ({1'b0, a} == 17'(DEPTH));
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [WORD_W-1:0] word;
		logic [WORD_W-1:0] shifted;
		word = {1'b0, sample_word};
		shifted = {s.shreg[WORD_W-2:0], word[s.sel_code[3:0]]};
		next_s = s;

		// Parameter words, kept across a reset request
		if (link.param_valid) begin
			case (link.param_sel)
				PARAM_SEL: begin
					next_s.sel_code = link.param_data;
				end
				PARAM_TRIG: begin
					next_s.trig = link.param_data;
				end
				PARAM_COUNT: begin
					next_s.count = link.param_data;
				end
				default: begin
					next_s.count = s.count;
				end
			endcase
		end

		case (s.state)
			TBC_SEARCH: begin
				if (sample_edge) begin
					next_s.shreg = shifted;
					if (shifted == s.trig) begin
						next_s.state = TBC_STORE;
						next_s.addr = '0;
						next_s.triggered = 1'b1;
					end
				end
			end
			TBC_STORE: begin
				if (at_end(s.addr, s.count)) begin
					next_s.state = TBC_READY;
					next_s.clipped = (s.addr != s.count);
				end else if (sample_edge) begin
					next_s.mem[s.addr[AW-1:0]] = word;
					next_s.addr = s.addr + 16'h0001;
				end
			end
			TBC_READY: begin
				if (link.unload_req) begin
					next_s.state = TBC_UNLOAD;
					next_s.uaddr = '0;
				end
			end
			TBC_UNLOAD: begin
				if (!s.xv || link.xfer_ready) begin
					if (s.uaddr == s.addr) begin
						next_s.xv = 1'b0;
						next_s.xl = 1'b0;
						next_s.state = TBC_IDLE;
					end else begin
						next_s.xv = 1'b1;
						next_s.xd = s.mem[s.uaddr[AW-1:0]];
						next_s.xl = (s.uaddr + 16'h0001) == s.addr;
						next_s.uaddr = s.uaddr + 16'h0001;
					end
				end
			end
			TBC_IDLE: begin
				next_s.state = TBC_IDLE;
			end
			default: begin
				next_s.state = TBC_IDLE;
			end
		endcase

		// Start begins a fresh search from any state
		if (link.start) begin
			next_s.state = TBC_SEARCH;
			next_s.shreg = '0;
			next_s.addr = '0;
			next_s.xv = 1'b0;
			next_s.xl = 1'b0;
			next_s.triggered = 1'b0;
			next_s.clipped = 1'b0;
		end

		// Abort wins over start and the state case for state, shift register and transfer flags in the same cycle
		if (link.abort) begin
			next_s.state = TBC_IDLE;
			next_s.shreg = '0;
			next_s.xv = 1'b0;
			next_s.xl = 1'b0;
		end

		next_s.csr = '0;
		next_s.csr[4:0] = next_s.state;
		next_s.csr[8] = next_s.triggered;
		next_s.csr[9] = next_s.clipped;
		next_s.csr[READY_BIT] = (next_s.state == TBC_READY) ||
			(next_s.state == TBC_UNLOAD);
		next_s.csr[11] = (next_s.state == TBC_UNLOAD);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.state <= TBC_IDLE;
			s.csr <= 16'h0001;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// Link outputs
	// ****************************************************************
	assign link.xfer_valid = s.xv;
	assign link.xfer_last  = s.xl;
	assign link.xfer_data  = s.xd;
	assign link.csr        = s.csr;
endmodule

/* src/tbc_host.sv */
// Host end: AXI4-Lite registers, parameter load and unload DMA
`timescale 1ns/1ns
module tbc_host
	import tbc_pkg::*;
#(
	parameter int RX_DEPTH = RX_DEPTH_DEF
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq,
	tbc_link_if.host         link
);
	if (RX_DEPTH < 1 || RX_DEPTH > 256) begin : g_bad_rx
		$error("tbc_host: RX_DEPTH out of range");
	end

	typedef struct packed {
		tbc_host_state_type              state;
		logic                            awready;
		logic                            wready;
		logic                            bvalid;
		logic [1:0]                      bresp;
		logic [11:0]                     awaddr;
		logic [31:0]                     wdata;
		logic [3:0]                      wstrb;
		logic                            arready;
		logic                            rvalid;
		logic [1:0]                      rresp;
		logic [31:0]                     rdata;
		logic [2:0][15:0]                param;
		logic [15:0]                     bytes;
		logic [IRQ_W-1:0]                istat;
		logic [IRQ_W-1:0]                imask;
		logic                            irq;
		logic [1:0]                      lidx;
		logic                            start;
		logic                            abort;
		logic                            pvalid;
		logic [1:0]                      psel;
		logic [15:0]                     pdata;
		logic                            ureq;
		logic                            xready;
		logic [RX_DEPTH-1:0][15:0]       rx;
		logic [15:0]                     rxn;
		logic                            rdy_prev;
	} tbc_host_type;

	tbc_host_type s;
	tbc_host_type next_s;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] st);
		return {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
	endfunction

	always_comb begin
		logic [IRQ_W-1:0] ev;
		logic [15:0]      cmd;
		logic [9:0]       ri;
		ev = '0;
		cmd = '0;
		ri = '0;
		next_s = s;
		next_s.start = 1'b0;
		next_s.abort = 1'b0;
		next_s.pvalid = 1'b0;
		next_s.ureq = 1'b0;

		// ************************************************************
		// Write channel
		// ************************************************************
		if (s_axi_awvalid && s.awready) begin
			next_s.awaddr = s_axi_awaddr;
			next_s.awready = 1'b0;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
			next_s.wready = 1'b0;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end
		if (!s.awready && !s.wready && !s.bvalid) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.awaddr)
				REG_CMD: begin
					cmd = merge(16'h0000, s.wdata, s.wstrb);
				end
				REG_SEL: begin
					next_s.param[0] = merge(s.param[0], s.wdata, s.wstrb);
				end
				REG_TRIG: begin
					next_s.param[1] = merge(s.param[1], s.wdata, s.wstrb);
				end
				REG_COUNT: begin
					next_s.param[2] = merge(s.param[2], s.wdata, s.wstrb);
				end
				REG_BYTES: begin
					next_s.bytes = merge(s.bytes, s.wdata, s.wstrb);
				end
				REG_ISTAT: begin
					next_s.istat = s.istat & ~(s.wdata[IRQ_W-1:0] & {IRQ_W{s.wstrb[0]}});
				end
				REG_IMASK: begin
					if (s.wstrb[0]) begin
						next_s.imask = s.wdata[IRQ_W-1:0];
					end
				end
				default: begin
					next_s.bresp = RESP_SLVERR;
				end
			endcase
		end

		// ************************************************************
		// Read channel
		// ************************************************************
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
		if (s_axi_arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = '0;
			ri = s_axi_araddr[11:2] - REG_RXBUF[11:2];
			case (s_axi_araddr)
				REG_CMD: begin
					next_s.rdata = '0;
				end
				REG_SEL: begin
					next_s.rdata[15:0] = s.param[0];
				end
				REG_TRIG: begin
					next_s.rdata[15:0] = s.param[1];
				end
				REG_COUNT: begin
					next_s.rdata[15:0] = s.param[2];
				end
				REG_BYTES: begin
					next_s.rdata[15:0] = s.bytes;
				end
				REG_CSR: begin
					next_s.rdata[15:0] = link.csr;
				end
				REG_ISTAT: begin
					next_s.rdata[IRQ_W-1:0] = s.istat;
				end
				REG_IMASK: begin
					next_s.rdata[IRQ_W-1:0] = s.imask;
				end
				default: begin
					if (s_axi_araddr >= REG_RXBUF && s_axi_araddr[1:0] == 2'h0 &&
						int'(ri) < RX_DEPTH) begin
						next_s.rdata[15:0] = s.rx[ri];
					end else begin
						next_s.rresp = RESP_SLVERR;
					end
				end
			endcase
		end

		// ************************************************************
		// Command sequencing
		// ************************************************************
		case (s.state)
			TBC_H_LOAD: begin
				next_s.pvalid = 1'b1;
				next_s.psel = s.lidx;
				next_s.pdata = s.param[s.lidx];
				next_s.lidx = s.lidx + 2'h1;
				if (s.lidx == PARAM_COUNT) begin
					next_s.state = TBC_H_IDLE;
				end
			end
			TBC_H_DMA: begin
				if (link.xfer_valid && s.xready) begin
					if (int'(s.rxn) < RX_DEPTH) begin
						next_s.rx[s.rxn[7:0]] = link.xfer_data;
					end
					next_s.rxn = s.rxn + 16'h0001;
					if (link.xfer_last) begin
						next_s.xready = 1'b0;
						next_s.state = TBC_H_IDLE;
						ev[IRQ_DONE] = 1'b1;
					end
				end
			end
			TBC_H_IDLE: begin
				if (cmd[CMD_LOAD]) begin
					next_s.state = TBC_H_LOAD;
					next_s.lidx = PARAM_SEL;
				end else if (cmd[CMD_READ]) begin
					if (!link.csr[READY_BIT] || s.bytes < {s.param[2][14:0], 1'b0} ||
						int'(s.param[2]) > RX_DEPTH) begin
						ev[IRQ_REFUSE] = 1'b1;
					end else if (s.param[2] == 16'h0000) begin
						ev[IRQ_DONE] = 1'b1;
					end else begin
						next_s.ureq = 1'b1;
						next_s.xready = 1'b1;
						next_s.rxn = '0;
						next_s.state = TBC_H_DMA;
					end
				end
			end
			default: begin
				next_s.state = TBC_H_IDLE;
			end
		endcase
		if (cmd[CMD_START]) begin
			next_s.start = 1'b1;
		end
		if (cmd[CMD_RESET]) begin
			next_s.abort = 1'b1;
			next_s.xready = 1'b0;
			next_s.state = TBC_H_IDLE;
		end

		// ************************************************************
		// Interrupts
		// ************************************************************
		next_s.rdy_prev = link.csr[READY_BIT];
		ev[IRQ_READY] = link.csr[READY_BIT] & ~s.rdy_prev;
		next_s.istat = next_s.istat | ev;
		next_s.irq = |(next_s.istat & next_s.imask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.state <= TBC_H_IDLE;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready    = s.awready;
	assign s_axi_wready     = s.wready;
	assign s_axi_bvalid     = s.bvalid;
	assign s_axi_bresp      = s.bresp;
	assign s_axi_arready    = s.arready;
	assign s_axi_rvalid     = s.rvalid;
	assign s_axi_rresp      = s.rresp;
	assign s_axi_rdata      = s.rdata;
	assign irq              = s.irq;
	assign link.start       = s.start;
	assign link.abort       = s.abort;
	assign link.param_valid = s.pvalid;
	assign link.param_sel   = s.psel;
	assign link.param_data  = s.pdata;
	assign link.unload_req  = s.ureq;
	assign link.xfer_ready  = s.xready;
endmodule

/* testbench/tbc_link_props.sv */
// Concurrent checks on the link between the host end and the device end
`timescale 1ns/1ns
module tbc_link_props
	import tbc_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        start,
	input wire logic        abort,
	input wire logic        unload_req,
	input wire logic        xfer_valid,
	input wire logic        xfer_ready,
	input wire logic        xfer_last,
	input wire logic [15:0] xfer_data,
	input wire logic [15:0] csr
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_ready_flag: assert property (csr[READY_BIT] == (csr[3] | csr[4]))
		else $error("ready flag out of step with state");
	a_debug_zero: assert property (csr[15:12] == 4'h0)
		else $error("unused status bits set");
	a_start_search: assert property (start && !abort |=> csr[4:0] == 5'h02)
		else $error("start did not begin search");
	a_abort_idle: assert property (abort |=> csr[4:0] == 5'h01)
		else $error("reset request did not reach idle");
	a_store_first: assert property ($rose(csr[3]) |-> $past(csr[2]))
		else $error("ready reached without storing");
	a_trig_seen: assert property (csr[2] |-> csr[8])
		else $error("storing without trigger");
	a_word_top: assert property (xfer_valid |-> !xfer_data[15])
		else $error("unused word bit set");
	a_xfer_when: assert property (xfer_valid |-> csr[READY_BIT])
		else $error("word sent while not ready");
	a_xfer_hold: assert property (
		xfer_valid && !xfer_ready && !abort |=> xfer_valid && $stable(xfer_data))
		else $error("offered word changed");
	a_unload_go: assert property (unload_req && csr[3] && !abort && !start |=> csr[4])
		else $error("unload request ignored");
	a_last_idle: assert property (
		xfer_valid && xfer_ready && xfer_last && !start |=> csr[4:0] == 5'h01 && !xfer_valid)
		else $error("no idle after last word");
endmodule

/* testbench/tb_top.sv */
// Self-checking bench joining the host end and the device end
`timescale 1ns/1ns
module tb_top
	import tbc_pkg::*;
;
	// Rows: select, trigger, count, ready status, words kept, idle status
	localparam logic [95:0] ROWS [4] = '{
		96'h0000_aaaa_0005_0508_0005_0101, 96'h0005_5555_0001_0508_0001_0101,
		96'h0000_aaaa_0014_0708_0010_0301, 96'h000a_aaaa_0008_0508_0008_0101};
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        irq;
	logic [2:0]  ph = 3'h0;
	logic [4:0]  n = 5'h0;
	logic [9:0]  omask = 10'h0;
	logic [14:0] lane_data;
	logic [9:0]  own_clk;
	logic [4:0]  timing_clk;
	int          error_cnt = 0;
	int          checks_done = 0;
	// Lanes change on the falling sampling edge; two timing clocks are faulty
	assign lane_data = {n, n, n};
	assign own_clk = {10{ph[2]}} & omask;
	assign timing_clk = {{3{ph[2]}}, 2'b01};
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		ph <= ph + 3'h1;
		if (ph == 3'h7)
			n <= n + 5'h1;
	end
	tbc_link_if i_tbc_link_if ();
	// Small buffer so a capture is cut at its end
	tbc_device #(.DEPTH(16)) i_tbc_device (.aclk(aclk), .aresetn(aresetn),
		.lane_data(lane_data), .own_clk(own_clk), .timing_clk(timing_clk),
		.link(i_tbc_link_if));
	tbc_host i_tbc_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq), .link(i_tbc_link_if));
	tbc_link_props i_tbc_link_props (.aclk(aclk), .aresetn(aresetn),
		.start(i_tbc_link_if.start), .abort(i_tbc_link_if.abort),
		.unload_req(i_tbc_link_if.unload_req), .xfer_valid(i_tbc_link_if.xfer_valid),
		.xfer_ready(i_tbc_link_if.xfer_ready), .xfer_last(i_tbc_link_if.xfer_last),
		.xfer_data(i_tbc_link_if.xfer_data), .csr(i_tbc_link_if.csr));
	// ****************************************
	// Bus cycles and comparison
	// ****************************************
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input int b);
		logic [1:0] r;
		wr(REG_CMD, 32'h1 << b, r);
	endtask
	task automatic poll(input logic [11:0] a, input int b);
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 400; i++) begin
			rd(a, d, r);
			if (d[b] === 1'b1)
				break;
		end
	endtask
	task automatic load(input logic [15:0] s, t, c);
		logic [1:0] r;
		wr(REG_SEL, {16'h0, s}, r);
		wr(REG_TRIG, {16'h0, t}, r);
		wr(REG_COUNT, {16'h0, c}, r);
		wr(REG_BYTES, {15'h0, c, 1'b0}, r);
		cmd(CMD_LOAD);
		repeat (8) @(posedge aclk);
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (60000) @(posedge aclk);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [15:0] sel;
		logic [15:0] trig;
		logic [15:0] cnt;
		logic [4:0]  m;
		logic [15:0] xcsr;
		logic [15:0] nw;
		logic [15:0] xend;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(REG_CSR, d, r);
		chk(d, 32'h1);
		chk(irq, 1'b0);
		wr(REG_IMASK, 32'h1, r);
		for (int k = 0; k < 4; k++) begin
			{sel, trig, cnt, xcsr, nw, xend} = ROWS[k];
			omask <= (sel < 16'ha) ? 10'h1 << sel : 10'h0;
			load(sel, trig, cnt);
			cmd(CMD_START);
			poll(REG_CSR, READY_BIT);
			rd(REG_CSR, d, r);
			chk(d, {16'h0, xcsr});
			chk(irq, 1'b1);
			cmd(CMD_READ);
			poll(REG_ISTAT, IRQ_DONE);
			for (int i = 0; i < nw; i++) begin
				rd(REG_RXBUF + 12'(4 * i), d, r);
				if (i == 0)
					m = d[4:0];
				if (i == 0)
					chk(d[0], {31'h0, ~trig[0]});
				chk(d, {17'h0, m, m, m});
				m = m + 5'h1;
			end
			rd(REG_CSR, d, r);
			chk(d, {16'h0, xend});
			wr(REG_ISTAT, 32'h7, r);
			repeat (2) @(posedge aclk);
			chk(irq, 1'b0);
		end
		// Abort mid-search, then restart on kept parameters
		cmd(CMD_START);
		rd(REG_CSR, d, r);
		chk(d[4:0], 5'h2);
		cmd(CMD_READ);
		rd(REG_ISTAT, d, r);
		chk(d, 32'h4);
		cmd(CMD_RESET);
		rd(REG_CSR, d, r);
		chk(d, 32'h1);
		cmd(CMD_START);
		poll(REG_CSR, READY_BIT);
		rd(REG_CSR, d, r);
		chk(d, 32'h508);
		wr(REG_ISTAT, 32'h7, r);
		wr(REG_BYTES, 32'hf, r);
		cmd(CMD_READ);
		rd(REG_ISTAT, d, r);
		chk(d, 32'h4);
		rd(REG_CSR, d, r);
		chk(d, 32'h508);
		rd(12'h020, d, r);
		chk(r, RESP_SLVERR);
		wr(REG_CSR, 32'h0, r);
		chk(r, RESP_SLVERR);
		load(16'hf, 16'haaaa, 16'h4);
		cmd(CMD_START);
		repeat (300) @(posedge aclk);
		rd(REG_CSR, d, r);
		chk(d[4:0], 5'h2);
		tally_and_finish();
	end
endmodule
